// >>> hdl/io_diag_pkg.sv
// Constants and types shared by the port diagnostics block.
package io_diag_pkg;
  localparam int NUM_PORTS = 8;
  localparam int STA_LINK_SHORT = 7;
  localparam int STA_ACT_WARN = 6;
  localparam int STA_ACT_SHORT = 5;
  localparam int STA_SENSOR_VOLT = 4;
  localparam int STA_NO_ACT_SUPPLY = 2;
  localparam int STA_ACT_SUPPLY = 1;
  localparam int STA_SENSOR_SUPPLY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] VENDOR_ID_DEFAULT = 16'h0001;
  localparam logic [15:0] DEVICE_ID_DEFAULT = 16'h0001;
  typedef enum logic [1:0] {
    PIN_NO_INPUT = 2'h0,
    PIN_NC_INPUT = 2'h1,
    PIN_OUTPUT = 2'h2,
    PIN_LINK_SIO = 2'h3
  } pin_func_e;
  typedef enum logic [1:0] {
    STORE_OFF = 2'h0,
    STORE_DELETE = 2'h1,
    STORE_RESTORE = 2'h2,
    STORE_SAVE_RESTORE = 2'h3
  } store_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_UPLOAD = 3'b010,
    ST_DOWNLOAD = 3'b100
  } store_state_e;
endpackage

// >>> hdl/io_port_diagnostics_control.sv
// Pin function, output protection, status bytes and parameter store for an eight-port I/O master.
`timescale 1ns/1ns
module io_port_diagnostics_control
  import io_diag_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] pin_func_i,
  input wire logic [7:0] safe_value_i,
  input wire logic global_diag_en_i,
  input wire logic sensor_uv_msg_en_i,
  input wire logic actuator_uv_msg_en_i,
  input wire logic output_short_msg_en_i,
  input wire logic manual_restart_cfg_i,
  input wire logic diag_enable_cfg_i,
  input wire logic [1:0] store_mode_i,
  input wire logic validate_cfg_i,
  input wire logic [15:0] cfg_vendor_id_i,
  input wire logic [15:0] cfg_device_id_i,
  input wire logic bus_ok_i,
  input wire logic exchange_i,
  input wire logic [7:0] output_cmd_i,
  input wire logic [7:0] output_restart_control_i,
  input wire logic [7:0] link_diag_enable_i,
  input wire logic [7:0] pin_level_i,
  input wire logic [7:0] diag_input_i,
  input wire logic [7:0] output_short_i,
  input wire logic [7:0] output_voltage_i,
  input wire logic [7:0] sensor_short_i,
  input wire logic [7:0] link_short_i,
  input wire logic [7:0] link_comm_i,
  input wire logic [7:0] link_pd_valid_i,
  input wire logic [7:0] link_error_i,
  input wire logic sensor_supply_low_i,
  input wire logic actuator_supply_low_i,
  input wire logic actuator_supply_missing_i,
  input wire logic [2:0] dev_port_i,
  input wire logic dev_present_i,
  input wire logic [15:0] dev_vendor_id_i,
  input wire logic [15:0] dev_device_id_i,
  input wire logic dev_upload_flag_i,
  input wire logic dev_params_differ_i,
  input wire logic xfer_done_i,
  output logic [7:0] pin_drive_o,
  output logic [7:0] input_state_o,
  output logic [7:0] actuator_short_status_o,
  output logic [7:0] actuator_warning_status_o,
  output logic [7:0] link_comm_status_o,
  output logic [7:0] port_error_status_o,
  output logic [7:0] sensor_supply_short_status_o,
  output logic [7:0] station_fault_status_o,
  output logic [7:0] process_data_valid_status_o,
  output logic [7:0] link_start_o,
  output logic diag_msg_o,
  output logic [7:0] diag_msg_flags_o,
  output logic upload_o,
  output logic download_o,
  output logic store_valid_o
);
  logic [7:0] is_output;
  logic [7:0] is_nc;
  logic [7:0] is_sio;
  logic [7:0] latched_off_r;
  logic [7:0] latched_off_nxt;
  logic [7:0] out_req;
  logic [7:0] link_diag_mask;
  logic [7:0] station_nxt;
  logic [7:0] id_match;
  logic [7:0] store_full_r;
  logic [15:0] store_vendor_r [NUM_PORTS];
  logic [15:0] store_device_r [NUM_PORTS];
  logic [2:0] xfer_port_r;
  store_state_e state_r;
  store_state_e state_nxt;
  store_mode_e mode;
  logic port_match;
  logic want_upload;
  logic want_download;

  genvar g;
  for (g = 0; g < NUM_PORTS; g++) begin : g_pin
    assign is_output[g] = pin_func_i[2*g +: 2] == PIN_OUTPUT;
    assign is_nc[g] = pin_func_i[2*g +: 2] == PIN_NC_INPUT;
    assign is_sio[g] = pin_func_i[2*g +: 2] == PIN_LINK_SIO;
    assign id_match[g] = !validate_cfg_i ||
      (dev_vendor_id_i == cfg_vendor_id_i && dev_device_id_i == cfg_device_id_i);
  end

  assign out_req = bus_ok_i ? output_cmd_i : safe_value_i;
  assign pin_drive_o = is_output & out_req & ~latched_off_r;
  assign input_state_o = ((pin_level_i ^ is_nc) & ~is_output) | diag_input_i;
  assign latched_off_nxt = manual_restart_cfg_i ?
    ((latched_off_r | (output_short_i & is_output)) & ~output_restart_control_i) : 8'h00;

  assign link_diag_mask = diag_enable_cfg_i ? link_diag_enable_i : 8'hff;
  assign link_start_o = dev_present_i ? (id_match & (8'h01 << dev_port_i)) : 8'h00;

  assign station_nxt = {|(link_short_i & link_diag_mask),
                        |(output_voltage_i & is_output),
                        |(output_short_i & is_output),
                        |sensor_short_i,
                        1'b0,
                        actuator_supply_missing_i,
                        actuator_supply_low_i,
                        sensor_supply_low_i};

  assign diag_msg_flags_o = global_diag_en_i ? {station_nxt[7:3],
                        station_nxt[2] & actuator_uv_msg_en_i,
                        station_nxt[1] & actuator_uv_msg_en_i,
                        station_nxt[0] & sensor_uv_msg_en_i} & ~{2'b00, ~output_short_msg_en_i, 5'b00000}
                        : 8'h00;
  assign diag_msg_o = |diag_msg_flags_o;

  assign mode = store_mode_e'(store_mode_i);
  assign port_match = store_vendor_r[dev_port_i] == dev_vendor_id_i &&
                      store_device_r[dev_port_i] == dev_device_id_i;
  assign want_upload = dev_present_i && ((mode == STORE_RESTORE && !store_full_r[dev_port_i]) ||
    (mode == STORE_SAVE_RESTORE && (dev_upload_flag_i || !store_full_r[dev_port_i])));
  assign want_download = dev_present_i && store_full_r[dev_port_i] && port_match && dev_params_differ_i &&
    (mode == STORE_RESTORE || (mode == STORE_SAVE_RESTORE && !dev_upload_flag_i));
  assign upload_o = state_r == ST_UPLOAD;
  assign download_o = state_r == ST_DOWNLOAD;
  assign store_valid_o = store_full_r[dev_port_i];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (want_upload) begin
          state_nxt = ST_UPLOAD;
        end else if (want_download) begin
          state_nxt = ST_DOWNLOAD;
        end
      end
      ST_UPLOAD, ST_DOWNLOAD: begin
        if (xfer_done_i || mode == STORE_OFF || mode == STORE_DELETE) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      xfer_port_r <= 3'h0;
      latched_off_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      latched_off_r <= latched_off_nxt;
      if (state_r == ST_IDLE) begin
        xfer_port_r <= dev_port_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      store_full_r <= 8'h00;
    end else if (mode == STORE_DELETE) begin
      store_full_r <= 8'h00;
    end else if (state_r == ST_UPLOAD && xfer_done_i) begin
      store_full_r[xfer_port_r] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (state_r == ST_UPLOAD && xfer_done_i) begin
      store_vendor_r[xfer_port_r] <= dev_vendor_id_i;
      store_device_r[xfer_port_r] <= dev_device_id_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      actuator_short_status_o <= STATUS_RESET;
      actuator_warning_status_o <= STATUS_RESET;
      link_comm_status_o <= STATUS_RESET;
      port_error_status_o <= STATUS_RESET;
      sensor_supply_short_status_o <= STATUS_RESET;
      station_fault_status_o <= STATUS_RESET;
      process_data_valid_status_o <= STATUS_RESET;
    end else if (exchange_i) begin
      actuator_short_status_o <= output_short_i & is_output & out_req;
      actuator_warning_status_o <= output_voltage_i & is_output & ~out_req;
      link_comm_status_o <= link_comm_i;
      port_error_status_o <= link_error_i | (output_short_i & is_output) | sensor_short_i;
      sensor_supply_short_status_o <= sensor_short_i;
      station_fault_status_o <= station_nxt;
      process_data_valid_status_o <= link_pd_valid_i & link_comm_i & is_sio;
    end
  end

  property p_safe_state;
    @(posedge sys_clk_i) disable iff (reset_i)
      (!bus_ok_i && latched_off_r == 8'h00)
      |-> pin_drive_o == (is_output & safe_value_i);
  endproperty
  a_safe_state: assert property (p_safe_state) else $error("Safe value not driven on bus loss.");

  property p_restart_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (manual_restart_cfg_i && is_output[0] && output_short_i[0] && !output_restart_control_i[0]) ##1
      (manual_restart_cfg_i && !output_restart_control_i[0]) |-> !pin_drive_o[0];
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("Shorted output restarted.");
  property p_global_block;
    @(posedge sys_clk_i) disable iff (reset_i) !global_diag_en_i |-> !diag_msg_o;
  endproperty
  a_global_block: assert property (p_global_block) else $error("Message while globally blocked.");
  property p_refresh;
    @(posedge sys_clk_i) disable iff (reset_i) exchange_i |=> link_comm_status_o == $past(link_comm_i);
  endproperty
  a_refresh: assert property (p_refresh) else $error("Status not refreshed.");
  property p_station;
    @(posedge sys_clk_i) disable iff (reset_i) exchange_i |=>
      station_fault_status_o[3] == 1'b0 && station_fault_status_o[0] == $past(sensor_supply_low_i);
  endproperty
  a_station: assert property (p_station) else $error("Station byte layout wrong.");
  property p_no_xfer_off;
    @(posedge sys_clk_i) disable iff (reset_i) mode == STORE_OFF ##1 mode == STORE_OFF |-> state_r == ST_IDLE;
  endproperty
  a_no_xfer_off: assert property (p_no_xfer_off) else $error("Transfer in off mode.");
  property p_delete;
    @(posedge sys_clk_i) disable iff (reset_i) mode == STORE_DELETE |=> store_full_r == 8'h00;
  endproperty
  a_delete: assert property (p_delete) else $error("Store not erased.");
  property p_start_gate;
    @(posedge sys_clk_i) disable iff (reset_i) validate_cfg_i && dev_vendor_id_i != cfg_vendor_id_i
      |-> link_start_o == 8'h00;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("Link started on mismatch.");

  property p_sensor_uv_block;
    @(posedge sys_clk_i) disable iff (reset_i)
      !sensor_uv_msg_en_i
      |-> !diag_msg_flags_o[STA_SENSOR_SUPPLY];
  endproperty
  a_sensor_uv_block: assert property (p_sensor_uv_block) else $error("Sensor undervoltage not blocked.");

  property p_actuator_uv_block;
    @(posedge sys_clk_i) disable iff (reset_i)
      !actuator_uv_msg_en_i
      |-> !diag_msg_flags_o[STA_ACT_SUPPLY] && !diag_msg_flags_o[STA_NO_ACT_SUPPLY];
  endproperty
  a_actuator_uv_block: assert property (p_actuator_uv_block) else $error("Actuator undervoltage not blocked.");

  property p_short_msg_block;
    @(posedge sys_clk_i) disable iff (reset_i)
      !output_short_msg_en_i
      |-> !diag_msg_flags_o[STA_ACT_SHORT];
  endproperty
  a_short_msg_block: assert property (p_short_msg_block) else $error("Output short message not blocked.");

  property p_short_msg_inputs;
    @(posedge sys_clk_i) disable iff (reset_i)
      (output_short_i & is_output) == 8'h00
      |-> !diag_msg_flags_o[STA_ACT_SHORT];
  endproperty
  a_short_msg_inputs: assert property (p_short_msg_inputs) else $error("Short message from an input pin.");

  property p_drive_outputs_only;
    @(posedge sys_clk_i) disable iff (reset_i)
      1'b1
      |-> (pin_drive_o & ~is_output) == 8'h00;
  endproperty
  a_drive_outputs_only: assert property (p_drive_outputs_only) else $error("Input pin driven.");

  property p_act_short;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i
      |=> (actuator_short_status_o & ~$past(output_short_i)) == 8'h00;
  endproperty
  a_act_short: assert property (p_act_short) else $error("Short flagged without short.");

  property p_act_warn;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i
      |=> (actuator_warning_status_o & ~$past(output_voltage_i)) == 8'h00;
  endproperty
  a_act_warn: assert property (p_act_warn) else $error("Warning flagged without voltage.");

  property p_restart_clear;
    @(posedge sys_clk_i) disable iff (reset_i)
      manual_restart_cfg_i && output_restart_control_i[0]
      |=> !latched_off_r[0];
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("Restart bit ignored.");

  property p_diag_mask;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i && diag_enable_cfg_i && (link_short_i & link_diag_enable_i) == 8'h00
      |=> !station_fault_status_o[STA_LINK_SHORT];
  endproperty
  a_diag_mask: assert property (p_diag_mask) else $error("Disabled link diagnostic reported.");

  property p_port_error;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i
      |=> (port_error_status_o & $past(link_error_i)) == $past(link_error_i);
  endproperty
  a_port_error: assert property (p_port_error) else $error("Port error not reported.");

  property p_sensor_short;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i
      |=> sensor_supply_short_status_o == $past(sensor_short_i);
  endproperty
  a_sensor_short: assert property (p_sensor_short) else $error("Sensor short byte wrong.");

  property p_diag_input_map;
    @(posedge sys_clk_i) disable iff (reset_i)
      1'b1
      |-> (input_state_o & diag_input_i) == diag_input_i;
  endproperty
  a_diag_input_map: assert property (p_diag_input_map) else $error("Diagnostic input missing.");

  property p_pd_valid;
    @(posedge sys_clk_i) disable iff (reset_i)
      exchange_i
      |=> (process_data_valid_status_o & ~$past(link_comm_i)) == 8'h00;
  endproperty
  a_pd_valid: assert property (p_pd_valid) else $error("Valid without link.");

  property p_hold_status;
    @(posedge sys_clk_i) disable iff (reset_i)
      !exchange_i
      |=> $stable(link_comm_status_o);
  endproperty
  a_hold_status: assert property (p_hold_status) else $error("Status changed between exchanges.");

  property p_delete_idle;
    @(posedge sys_clk_i) disable iff (reset_i)
      mode == STORE_DELETE ##1 mode == STORE_DELETE
      |-> state_r == ST_IDLE;
  endproperty
  a_delete_idle: assert property (p_delete_idle) else $error("Transfer in delete mode.");

  property p_restore_upload;
    @(posedge sys_clk_i) disable iff (reset_i)
      state_r == ST_IDLE && mode == STORE_RESTORE && dev_present_i && !store_full_r[dev_port_i]
      |=> state_r == ST_UPLOAD;
  endproperty
  a_restore_upload: assert property (p_restore_upload) else $error("Empty store not uploaded.");

  property p_flag_upload;
    @(posedge sys_clk_i) disable iff (reset_i)
      state_r == ST_IDLE && mode == STORE_SAVE_RESTORE && dev_present_i && dev_upload_flag_i
      |=> state_r == ST_UPLOAD;
  endproperty
  a_flag_upload: assert property (p_flag_upload) else $error("Upload flag ignored.");

  property p_foreign_device;
    @(posedge sys_clk_i) disable iff (reset_i)
      state_r == ST_IDLE && dev_present_i && !port_match && !want_upload
      |=> state_r == ST_IDLE;
  endproperty
  a_foreign_device: assert property (p_foreign_device) else $error("Transfer to other device type.");

  c_restart: cover property (@(posedge sys_clk_i) latched_off_r[0] ##1 !latched_off_r[0]);
  c_upload: cover property (@(posedge sys_clk_i) state_r == ST_UPLOAD ##1 state_r == ST_IDLE);
  c_download: cover property (@(posedge sys_clk_i) state_r == ST_DOWNLOAD);
  c_bus_loss: cover property (@(posedge sys_clk_i) bus_ok_i ##1 !bus_ok_i);
endmodule

// >>> verification/fieldbus_ctrl_model.sv
// Fieldbus controller model that issues cyclic exchange pulses.
`timescale 1ns/1ns
module fieldbus_ctrl_model #(
  parameter int PERIOD = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  output logic exchange_o,
  output logic bus_ok_o
);
  logic [7:0] cnt_r;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 8'h00;
      exchange_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
      exchange_o <= run_i && (cnt_r == 8'h00);
    end
  end
  // Bus health drops when the controller stops running.
  assign bus_ok_o = run_i;
endmodule

// >>> verification/io_port_diagnostics_control_tb.sv
// Self-checking bench for the port diagnostics block.
`timescale 1ns/1ns
module io_port_diagnostics_control_tb;
  logic clk, rst, run, gde, sue, aue, ose, mrc, dec, vc, pr, uf, df, xd, sl, al, am, xch, bok, dm, up, dn, st;
  logic [15:0] pf, cv, cd, dv, dd;
  logic [7:0] sv, cmd, rb, lde, lvl, di, os, ov, ss, lsh, lc, lpv, le, pd, ins, ash, aw, lcs, pe, sss, sf, pdv, ls, mf;
  logic [1:0] sm;
  logic [2:0] dp;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  fieldbus_ctrl_model i_fieldbus_ctrl_model (.sys_clk_i(clk), .reset_i(rst), .run_i(run), .exchange_o(xch),
    .bus_ok_o(bok));
  io_port_diagnostics_control i_io_port_diagnostics_control (.sys_clk_i(clk), .reset_i(rst), .pin_func_i(pf),
    .safe_value_i(sv), .global_diag_en_i(gde), .sensor_uv_msg_en_i(sue), .actuator_uv_msg_en_i(aue),
    .output_short_msg_en_i(ose), .manual_restart_cfg_i(mrc), .diag_enable_cfg_i(dec), .store_mode_i(sm),
    .validate_cfg_i(vc), .cfg_vendor_id_i(cv), .cfg_device_id_i(cd), .bus_ok_i(bok), .exchange_i(xch),
    .output_cmd_i(cmd), .output_restart_control_i(rb), .link_diag_enable_i(lde), .pin_level_i(lvl),
    .diag_input_i(di), .output_short_i(os), .output_voltage_i(ov), .sensor_short_i(ss), .link_short_i(lsh),
    .link_comm_i(lc), .link_pd_valid_i(lpv), .link_error_i(le), .sensor_supply_low_i(sl),
    .actuator_supply_low_i(al), .actuator_supply_missing_i(am), .dev_port_i(dp), .dev_present_i(pr),
    .dev_vendor_id_i(dv), .dev_device_id_i(dd), .dev_upload_flag_i(uf), .dev_params_differ_i(df),
    .xfer_done_i(xd), .pin_drive_o(pd), .input_state_o(ins), .actuator_short_status_o(ash),
    .actuator_warning_status_o(aw), .link_comm_status_o(lcs), .port_error_status_o(pe),
    .sensor_supply_short_status_o(sss), .station_fault_status_o(sf), .process_data_valid_status_o(pdv),
    .link_start_o(ls), .diag_msg_o(dm), .diag_msg_flags_o(mf), .upload_o(up), .download_o(dn),
    .store_valid_o(st));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xwait;
    @(posedge clk iff xch);
    #1;
  endtask
  task automatic t_pins;
    @(posedge clk);
    pf <= 16'haaaa;
    cmd <= 8'h5a;
    sv <= 8'hc3;
    tick(1);
    chk("drive", 8'h5a, pd);
    @(posedge clk);
    run <= 1'b0;
    tick(1);
    chk("safe", 8'hc3, pd);
    @(posedge clk);
    run <= 1'b1;
    pf <= 16'h5500;
    lvl <= 8'h3c;
    tick(1);
    chk("drive_in", 8'h00, pd);
    chk("in_state", 8'hcc, ins);
    @(posedge clk);
    di <= 8'h01;
    tick(1);
    chk("diag_in", 8'hcd, ins);
    $display("test pins done");
  endtask
  task automatic t_status;
    @(posedge clk);
    {pf, cmd, ov, os, ss, lc, lpv, le, lsh} <= {16'haffa, 8'h81, 8'h42, 8'h81, 8'h10, 8'h24, 8'h3c, 8'h08, 8'h04};
    {sl, al, am, di} <= {1'b1, 1'b1, 1'b1, 8'h00};
    {gde, sue, aue, ose} <= 4'hf;
    xwait();
    chk("act_short", 8'h81, ash);
    chk("act_warn", 8'h42, aw);
    chk("link_comm", 8'h24, lcs);
    chk("port_err", 8'h99, pe);
    chk("sens_short", 8'h10, sss);
    chk("station", 8'hf7, sf);
    chk("pd_valid", 8'h24, pdv);
    chk("msg", 8'h01, {7'h00, dm});
    chk("msg_us", 8'h01, {7'h00, mf[0]});
    chk("msg_ua", 8'h01, {7'h00, mf[1]});
    chk("msg_sc", 8'h01, {7'h00, mf[5]});
    @(posedge clk);
    {sue, aue, ose} <= 3'h0;
    tick(1);
    chk("msg_us_off", 8'h00, {7'h00, mf[0]});
    chk("msg_ua_off", 8'h00, {7'h00, mf[1]});
    chk("msg_sc_off", 8'h00, {7'h00, mf[5]});
    chk("station_kept", 8'hf7, sf);
    @(posedge clk);
    gde <= 1'b0;
    tick(1);
    chk("msg_off", 8'h00, {7'h00, dm});
    xwait();
    chk("station_msg_off", 8'hf7, sf);
    $display("test status done");
  endtask
  task automatic t_restart;
    @(posedge clk);
    {pf, cmd, mrc, os} <= {16'h0002, 8'h01, 1'b1, 8'h00};
    @(posedge clk);
    os <= 8'h01;
    @(posedge clk);
    os <= 8'h00;
    tick(2);
    chk("latched_off", 8'h00, pd);
    @(posedge clk);
    rb <= 8'h01;
    @(posedge clk);
    rb <= 8'h00;
    #1;
    chk("restarted", 8'h01, pd);
    $display("test restart done");
  endtask
  task automatic t_diag;
    @(posedge clk);
    {dec, lde} <= {1'b1, 8'h00};
    xwait();
    xwait();
    chk("link_short_off", 8'h00, {7'h00, sf[7]});
    @(posedge clk);
    lde <= 8'h04;
    xwait();
    chk("link_short_on", 8'h01, {7'h00, sf[7]});
    $display("test diag done");
  endtask
  task automatic t_store;
    @(posedge clk);
    {pf, sm, pr, vc, dv, dd, cv, cd} <= {16'hffff, 2'h0, 1'b1, 1'b1, 16'h0123, 16'h0456, 16'h0123, 16'h0456};
    tick(2);
    chk("off_xfer", 8'h00, {6'h00, up, dn});
    chk("start", 8'h01, ls);
    @(posedge clk);
    {cv, sm} <= {16'h0124, 2'h3};
    tick(2);
    chk("no_start", 8'h00, ls);
    chk("upload", 8'h01, {7'h00, up});
    @(posedge clk);
    {pr, xd} <= 2'b01;
    @(posedge clk);
    {xd, sm} <= {1'b0, 2'h0};
    tick(1);
    chk("up_done", 8'h01, {6'h00, up, st});
    chk("kept", 8'h01, {7'h00, st});
    @(posedge clk);
    {sm, df, pr} <= {2'h2, 1'b1, 1'b1};
    tick(2);
    chk("download", 8'h01, {7'h00, dn});
    @(posedge clk);
    {xd, dv} <= {1'b1, 16'h0999};
    @(posedge clk);
    xd <= 1'b0;
    tick(2);
    chk("id_mismatch", 8'h00, {7'h00, dn});
    @(posedge clk);
    sm <= 2'h1;
    tick(2);
    chk("deleted", 8'h00, {5'h00, up, dn, st});
    @(posedge clk);
    sm <= 2'h2;
    tick(2);
    chk("restore_empty", 8'h01, {7'h00, up});
    $display("test store done");
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    {gde, sue, aue, ose, mrc, dec, vc, pr, uf, df, xd, sl, al, am} = '0;
    {pf, cv, cd, dv, dd, sv, cmd, rb, lde, lvl, di, os, ov, ss, lsh, lc, lpv, le, sm, dp} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    tick(1);
    chk("reset_station", 8'h00, sf);
    t_pins();
    t_status();
    t_restart();
    t_diag();
    t_store();
    tally_and_finish();
  end
endmodule
